// ==== logic/fhe_cause_encoder.sv ====
// Turns the set bits of the fault cause register into up to eight cause codes.
`default_nettype none

module fhe_cause_encoder #(
    parameter int WIDTH   = fhe_pkg::FAULT_WIDTH,
    parameter int SLOTS   = fhe_pkg::GROUP_SIZE,
    parameter int CODE_W  = fhe_pkg::CODE_WIDTH
) (
    input  wire logic [WIDTH-1:0]        cause_in,
    output logic      [SLOTS*CODE_W-1:0] codes_out
);

    if (WIDTH + 1 >= (1 << CODE_W)) begin : g_bad_width
        $error("Code width too small for the cause register.");
    end

    // Lowest bit first; bits past the eighth set bit are not recorded.
    always_comb begin
        int n;
        n = 0;
        codes_out = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (cause_in[i] && n < SLOTS) begin
                codes_out[n*CODE_W +: CODE_W] = CODE_W'(i + 1);
                n = n + 1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== logic/fhe_fault_enable.sv ====
// Fault counter, fault history access and drive enable state for the controller.
`default_nettype none

// Contract
// - Count fault conditions, saturating at 65,535; writing zero clears the count.
// - A rising bit in the 32-bit fault cause register is one fault condition.
// - Each fault condition stops motion and starts internal fault program four.
// - Each stored code is the set bit position plus one, 1 to 32.
// - History holds 64 entries as eight groups of eight, zero after power-up.
// - At most eight cause codes per condition; unused group entries hold zero.
// - Acknowledge and reset leave history untouched; only power cycle clears it.
// - New condition increments count, shifts history eight places, writes entries 1-8.
// - Read request carries index 1 to 64; device returns that entry.
// - A returned code of zero ends the cause list of a condition.
// - The newest condition always occupies indices one through eight.
// - Codes follow the fixed table; code 4 lost enable, 22 following error.
// - A fault disables the drive; enabling is refused until acknowledged and cleared.
// - Control bit 3 low disables the drive, high enables it.
// - Disabling through the control word never sets status fault bit 3.
// - Status bit 2 is one when enabled, zero when inhibited.
// - Drive stays enabled only while control bits 0 to 3 are all one.
// - Status bit 3 set while faulted; after acknowledge, enter switch-on inhibit.
module fhe_fault_enable #(
    parameter int FAULT_W = fhe_pkg::FAULT_WIDTH
) (
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic [FAULT_W-1:0]  fault_cause_in,
    input  wire logic [15:0]         control_word_in,
    input  wire logic                pkw_valid_in,
    input  wire logic [3:0]          pkw_task_in,
    input  wire logic [10:0]         pkw_pnu_in,
    input  wire logic [7:0]          pkw_index_in,
    input  wire logic [15:0]         pkw_wdata_in,
    output logic                     pkw_ack_out,
    output logic                     pkw_error_out,
    output logic      [15:0]         pkw_rdata_out,
    output logic      [15:0]         status_word_out,
    output logic                     drive_enable_out,
    output logic                     motion_stop_out,
    output logic                     program_start_out,
    output logic      [2:0]          program_number_out,
    output logic      [15:0]         fault_count_out
);

    localparam int CW = fhe_pkg::CODE_WIDTH;
    localparam int GS = fhe_pkg::GROUP_SIZE;

    if (FAULT_W != fhe_pkg::FAULT_WIDTH) begin : g_bad_fault_w
        $error("Fault cause register must be 32 bits wide.");
    end

    logic [FAULT_W-1:0]         cause_prev_reg;
    logic                       ack_prev_reg;
    logic [15:0]                count_reg;
    logic [15:0]                count_next;
    logic [15:0]                count_base;
    fhe_pkg::fhe_drive_state_t  state_reg;
    fhe_pkg::fhe_drive_state_t  state_next;
    logic [15:0]                status_next;
    logic                       ack_reg;
    logic                       error_reg;
    logic [15:0]                rdata_reg;
    logic                       stop_reg;
    logic                       start_reg;
    logic [2:0]                 program_reg;
    logic [15:0]                status_reg;
    logic                       enable_reg;

    wire  [FAULT_W-1:0]         cause_rise;
    wire                        fault_cond;
    wire                        ack_rise;
    wire                        cw_all_on;
    wire                        cause_clear;
    wire                        is_read;
    wire                        is_write;
    wire                        hit_count;
    wire                        hit_cause;
    wire                        index_ok;
    wire                        write_zero;
    wire                        req_good;
    wire  [5:0]                 rd_index;
    wire  [GS*CW-1:0]           new_codes;
    wire  [CW-1:0]              rd_code;
    wire  [CW-1:0]              head_code;
    wire  [15:0]                rdata_next;

    // Fault condition detection and acknowledge edge.
    assign cause_rise  = fault_cause_in & ~cause_prev_reg;
    assign fault_cond  = |cause_rise;
    assign ack_rise    = control_word_in[fhe_pkg::CW_ACK] & ~ack_prev_reg;
    assign cause_clear = (fault_cause_in == '0);
    assign cw_all_on   = (control_word_in[3:0] == fhe_pkg::CW_ENABLE_ALL);

    // Parameter channel decode.
    assign is_read    = pkw_valid_in && (pkw_task_in == fhe_pkg::TASK_READ);
    assign is_write   = pkw_valid_in && (pkw_task_in == fhe_pkg::TASK_WRITE);
    assign hit_count  = (pkw_pnu_in == fhe_pkg::PNU_COUNT);
    assign hit_cause  = (pkw_pnu_in == fhe_pkg::PNU_CAUSE);
    assign index_ok   = (pkw_index_in >= fhe_pkg::INDEX_FIRST) && (pkw_index_in <= fhe_pkg::INDEX_LAST);
    assign write_zero = is_write && hit_count && (pkw_wdata_in == fhe_pkg::COUNT_RESET);
    assign req_good   = (is_read && hit_count) || (is_read && hit_cause && index_ok) || write_zero;
    assign rd_index   = 6'(pkw_index_in - fhe_pkg::INDEX_FIRST);
    assign rdata_next = !req_good ? 16'h0000 :
                        (is_read && hit_count) ? count_reg :
                        (is_read && hit_cause) ? {10'h000, rd_code} : 16'h0000;

    // A fault in the same cycle as a clearing write still counts: the set wins.
    assign count_base = write_zero ? fhe_pkg::COUNT_RESET : count_reg;
    assign count_next = (fault_cond && count_base != fhe_pkg::COUNT_MAX) ?
                        16'(count_base + 16'h0001) : count_base;

    fhe_cause_encoder u_encoder (
        .cause_in  (fault_cause_in),
        .codes_out (new_codes)
    );

    fhe_history u_history (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .push_in       (fault_cond),
        .codes_in      (new_codes),
        .rd_index_in   (rd_index),
        .rd_code_out   (rd_code),
        .head_code_out (head_code)
    );

    // Drive state; a new fault condition overrides every other transition.
    always_comb begin
        state_next = state_reg;
        if (fault_cond) begin
            state_next = fhe_pkg::DRV_FAULT;
        end else begin
            case (state_reg)
                fhe_pkg::DRV_INHIBIT: begin
                    if (!control_word_in[fhe_pkg::CW_ON]) begin
                        state_next = fhe_pkg::DRV_READY;
                    end
                end
                fhe_pkg::DRV_READY: begin
                    if (cw_all_on) begin
                        state_next = fhe_pkg::DRV_ENABLED;
                    end
                end
                fhe_pkg::DRV_ENABLED: begin
                    if (!cw_all_on) begin
                        state_next = fhe_pkg::DRV_READY;
                    end
                end
                fhe_pkg::DRV_FAULT: begin
                    if (ack_rise && cause_clear) begin
                        state_next = fhe_pkg::DRV_INHIBIT;
                    end
                end
                default: begin
                    state_next = fhe_pkg::DRV_FAULT;
                end
            endcase
        end
    end

    always_comb begin
        status_next = 16'h0000;
        status_next[fhe_pkg::SW_READY_ON] = (state_next == fhe_pkg::DRV_READY) ||
                                            (state_next == fhe_pkg::DRV_ENABLED);
        status_next[fhe_pkg::SW_READY_OP] = (state_next == fhe_pkg::DRV_ENABLED);
        status_next[fhe_pkg::SW_ENABLED]  = (state_next == fhe_pkg::DRV_ENABLED);
        status_next[fhe_pkg::SW_FAULT]    = (state_next == fhe_pkg::DRV_FAULT);
        status_next[fhe_pkg::SW_NO_OFF2]  = control_word_in[1];
        status_next[fhe_pkg::SW_NO_OFF3]  = control_word_in[2];
        status_next[fhe_pkg::SW_INHIBIT]  = (state_next == fhe_pkg::DRV_INHIBIT);
    end

    // The edge register starts at zero, so a cause already set at release counts.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cause_prev_reg <= '0;
            ack_prev_reg   <= 1'b0;
        end else begin
            cause_prev_reg <= fault_cause_in;
            ack_prev_reg   <= control_word_in[fhe_pkg::CW_ACK];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg      <= fhe_pkg::COUNT_RESET;
            state_reg      <= fhe_pkg::DRV_INHIBIT;
        end else begin
            count_reg      <= count_next;
            state_reg      <= state_next;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_reg     <= 1'b0;
            error_reg   <= 1'b0;
            rdata_reg   <= 16'h0000;
        end else begin
            ack_reg     <= pkw_valid_in;
            error_reg   <= pkw_valid_in && !req_good;
            rdata_reg   <= rdata_next;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stop_reg    <= 1'b0;
            start_reg   <= 1'b0;
            program_reg <= 3'h0;
        end else begin
            stop_reg    <= fault_cond;
            start_reg   <= fault_cond;
            program_reg <= fault_cond ? fhe_pkg::FAULT_PROGRAM : program_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_reg <= fhe_pkg::STATUS_RESET;
            enable_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            enable_reg <= (state_next == fhe_pkg::DRV_ENABLED);
        end
    end

    assign pkw_ack_out        = ack_reg;
    assign pkw_error_out      = error_reg;
    assign pkw_rdata_out      = rdata_reg;
    assign status_word_out    = status_reg;
    assign drive_enable_out   = enable_reg;
    assign motion_stop_out    = stop_reg;
    assign program_start_out  = start_reg;
    assign program_number_out = program_reg;
    assign fault_count_out    = count_reg;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_count_incr: assert property (
        fault_cond && !write_zero && count_reg != fhe_pkg::COUNT_MAX
        |=> fault_count_out == 16'($past(count_reg) + 16'h0001))
        else $error("Fault count did not step by one.");

    a_count_sat: assert property (
        count_reg == fhe_pkg::COUNT_MAX && !write_zero
        |=> fault_count_out == fhe_pkg::COUNT_MAX)
        else $error("Fault count left saturation.");

    a_count_clear: assert property (
        write_zero
        |=> fault_count_out == {15'h0000, $past(fault_cond)})
        else $error("Writing zero did not clear the fault count.");

    a_fault_stop: assert property (
        fault_cond
        |=> motion_stop_out
        && program_start_out
        && program_number_out == fhe_pkg::FAULT_PROGRAM)
        else $error("Fault did not stop motion and start program four.");

    // A new rising bit on the very next edge is a new condition, so the pulse check keys on its absence.
    a_stop_pulse: assert property (
        !fault_cond
        |=> !motion_stop_out
        && !program_start_out)
        else $error("Stop pulse without a fault condition.");

    a_newest_first: assert property (
        fault_cond
        |=> head_code == $past(new_codes[CW-1:0]))
        else $error("Newest cause code not at the first history entry.");

    a_history_keep: assert property (
        !fault_cond
        |=> $stable(head_code))
        else $error("History changed without a fault condition.");

    a_fault_disable: assert property (
        fault_cond
        |=> !status_word_out[fhe_pkg::SW_ENABLED]
        && status_word_out[fhe_pkg::SW_FAULT]
        && !drive_enable_out)
        else $error("Fault did not disable the drive.");

    a_enable_drop: assert property (
        state_reg == fhe_pkg::DRV_ENABLED && !cw_all_on && !fault_cond
        |=> !drive_enable_out
        && !status_word_out[fhe_pkg::SW_ENABLED]
        && !status_word_out[fhe_pkg::SW_FAULT])
        else $error("Control word disable misbehaved.");

    a_enable_rise: assert property (
        state_reg == fhe_pkg::DRV_READY && cw_all_on && !fault_cond
        |=> drive_enable_out
        && status_word_out[fhe_pkg::SW_ENABLED])
        else $error("Drive did not enable.");

    a_fault_hold: assert property (
        state_reg == fhe_pkg::DRV_FAULT && !(ack_rise && cause_clear)
        |=> status_word_out[fhe_pkg::SW_FAULT]
        && !drive_enable_out)
        else $error("Fault cleared without acknowledge.");

    a_ack_clear: assert property (
        state_reg == fhe_pkg::DRV_FAULT && ack_rise && cause_clear && !fault_cond
        |=> !status_word_out[fhe_pkg::SW_FAULT]
        && status_word_out[fhe_pkg::SW_INHIBIT])
        else $error("Acknowledge did not reach switch-on inhibit.");

    a_read_return: assert property (
        is_read && hit_cause && index_ok
        |=> pkw_ack_out
        && !pkw_error_out
        && pkw_rdata_out == {10'h000, $past(rd_code)})
        else $error("History read returned the wrong entry.");

    a_read_refuse: assert property (
        pkw_valid_in && !req_good
        |=> pkw_ack_out
        && pkw_error_out
        && pkw_rdata_out == 16'h0000)
        else $error("Refused request was not flagged.");

    a_channel_idle: assert property (
        !pkw_valid_in
        |=> !pkw_ack_out
        && !pkw_error_out)
        else $error("Answer without a request.");

    c_fault_seen: cover property (fault_cond ##1 motion_stop_out);
    c_enabled: cover property (state_reg == fhe_pkg::DRV_READY ##1 drive_enable_out);
    c_history_read: cover property (is_read && hit_cause && index_ok ##1 pkw_ack_out);
    c_ack_recover: cover property (state_reg == fhe_pkg::DRV_FAULT ##1 state_reg == fhe_pkg::DRV_INHIBIT);
    c_count_clear: cover property (write_zero ##1 fault_count_out == 16'h0000);

endmodule

`default_nettype wire

// ==== logic/fhe_history.sv ====
// Volatile fault history: groups of cause codes shifted in newest first.
`default_nettype none

module fhe_history #(
    parameter int GROUPS  = fhe_pkg::HIST_GROUPS,
    parameter int GSIZE   = fhe_pkg::GROUP_SIZE,
    parameter int CODE_W  = fhe_pkg::CODE_WIDTH,
    parameter int DEPTH   = fhe_pkg::HIST_DEPTH
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      push_in,
    input  wire logic [GSIZE*CODE_W-1:0]   codes_in,
    input  wire logic [$clog2(DEPTH)-1:0]  rd_index_in,
    output logic      [CODE_W-1:0]         rd_code_out,
    output logic      [CODE_W-1:0]         head_code_out
);

    if (DEPTH != GROUPS * GSIZE) begin : g_bad_depth
        $error("History depth must equal groups times group size.");
    end

    logic [CODE_W-1:0] mem_reg [DEPTH];

    // Only the power-on reset clears entries; acknowledges never reach here.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (push_in) begin
            for (int i = DEPTH - 1; i >= GSIZE; i--) begin
                mem_reg[i] <= mem_reg[i-GSIZE];
            end
            for (int i = 0; i < GSIZE; i++) begin
                mem_reg[i] <= codes_in[i*CODE_W +: CODE_W];
            end
        end
    end

    assign rd_code_out   = mem_reg[rd_index_in];
    assign head_code_out = mem_reg[0];

endmodule

`default_nettype wire

// ==== logic/fhe_pkg.sv ====
// Shared constants and types for the fault history and drive enable block.
`default_nettype none

package fhe_pkg;

    localparam int          FAULT_WIDTH     = 32;
    localparam int          HIST_GROUPS     = 8;
    localparam int          GROUP_SIZE      = 8;
    localparam int          HIST_DEPTH      = 64;
    localparam int          CODE_WIDTH      = 6;
    localparam int          COUNT_WIDTH     = 16;
    localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [10:0] PNU_COUNT       = 11'h3B8;
    localparam logic [10:0] PNU_CAUSE       = 11'h3B3;
    localparam logic [3:0]  TASK_READ       = 4'h1;
    localparam logic [3:0]  TASK_WRITE      = 4'h2;
    localparam logic [7:0]  INDEX_FIRST     = 8'h01;
    localparam logic [7:0]  INDEX_LAST      = 8'h40;
    localparam logic [2:0]  FAULT_PROGRAM   = 3'h4;
    localparam logic [5:0]  CODE_LOST_EN    = 6'h04;
    localparam logic [5:0]  CODE_FOLLOW_ERR = 6'h16;
    localparam logic [3:0]  CW_ENABLE_ALL   = 4'hF;
    localparam int          CW_ON           = 0;
    localparam int          CW_ENABLE       = 3;
    localparam int          CW_ACK          = 7;
    localparam int          SW_READY_ON     = 0;
    localparam int          SW_READY_OP     = 1;
    localparam int          SW_ENABLED      = 2;
    localparam int          SW_FAULT        = 3;
    localparam int          SW_NO_OFF2      = 4;
    localparam int          SW_NO_OFF3      = 5;
    localparam int          SW_INHIBIT      = 6;
    localparam logic [15:0] STATUS_RESET    = 16'h0040;

    typedef enum logic [1:0] {
        DRV_INHIBIT,
        DRV_READY,
        DRV_ENABLED,
        DRV_FAULT
    } fhe_drive_state_t;

endpackage

`default_nettype wire

// ==== sim/fhe_fault_enable_tb.sv ====
// Self-checking testbench for the fault counter, history and drive enable block.
`default_nettype none

module fhe_fault_enable_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_in;
    logic        rst_n_in;
    logic [31:0] fault_cause_in;
    logic [15:0] control_word_in;
    logic        pkw_valid_in;
    logic [3:0]  pkw_task_in;
    logic [10:0] pkw_pnu_in;
    logic [7:0]  pkw_index_in;
    logic [15:0] pkw_wdata_in;
    logic        pkw_ack_out;
    logic        pkw_error_out;
    logic [15:0] pkw_rdata_out;
    logic [15:0] status_word_out;
    logic        drive_enable_out;
    logic        motion_stop_out;
    logic        program_start_out;
    logic [2:0]  program_number_out;
    logic [15:0] fault_count_out;
    int          miscompares;
    int          compares;
    int          cycles;

    fhe_fault_enable uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .fault_cause_in(fault_cause_in),
        .control_word_in(control_word_in), .pkw_valid_in(pkw_valid_in), .pkw_task_in(pkw_task_in),
        .pkw_pnu_in(pkw_pnu_in), .pkw_index_in(pkw_index_in), .pkw_wdata_in(pkw_wdata_in),
        .pkw_ack_out(pkw_ack_out), .pkw_error_out(pkw_error_out), .pkw_rdata_out(pkw_rdata_out),
        .status_word_out(status_word_out), .drive_enable_out(drive_enable_out),
        .motion_stop_out(motion_stop_out), .program_start_out(program_start_out),
        .program_number_out(program_number_out), .fault_count_out(fault_count_out));

    fhe_master_model m (.clk_in(clk_in), .ack_in(pkw_ack_out), .error_in(pkw_error_out),
        .rdata_in(pkw_rdata_out), .valid_out(pkw_valid_in), .task_out(pkw_task_in),
        .pnu_out(pkw_pnu_in), .index_out(pkw_index_in), .wdata_out(pkw_wdata_in),
        .control_word_out(control_word_in));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic finish_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang of the handshake must not stall the run; the sequence needs well under a thousand cycles.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic req(input logic [3:0] tid, input logic [10:0] pnu, input logic [7:0] idx,
                       input logic [15:0] wd, input logic exp_err, input logic [15:0] exp_rd);
        logic        got;
        logic        err;
        logic [15:0] rd;
        m.request(tid, pnu, idx, wd, int'(idx[1:0]), got, err, rd);
        check("ack", 16'h0001, {15'h0000, got});
        check("error", {15'h0000, exp_err}, {15'h0000, err});
        check("rdata", exp_rd, rd);
    endtask

    task automatic rd_entry(input logic [7:0] idx, input logic [15:0] exp);
        req(fhe_pkg::TASK_READ, fhe_pkg::PNU_CAUSE, idx, 16'h0000, 1'b0, exp);
    endtask

    task automatic ctl(input logic [15:0] cw, input logic [15:0] exp_status);
        m.set_control(cw);
        repeat (2) @(negedge clk_in);
        check("status", exp_status, status_word_out);
        check("enable", {15'h0000, exp_status[2]}, {15'h0000, drive_enable_out});
    endtask

    // Raises the cause bits and expects exactly one stop pulse with the fault program request.
    task automatic raise_fault(input logic [31:0] cause, input logic [15:0] exp_count);
        int seen;
        seen = 0;
        @(negedge clk_in);
        fault_cause_in = cause;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            if (motion_stop_out === 1'b1) begin
                seen++;
                check("start", 16'h0001, {15'h0000, program_start_out});
            end
        end
        check("stop pulses", 16'h0001, seen[15:0]);
        check("program", {13'h0000, fhe_pkg::FAULT_PROGRAM}, {13'h0000, program_number_out});
        check("count", exp_count, fault_count_out);
        check("fault bits", 16'h0008, status_word_out & 16'h000C);
        check("enable", 16'h0000, {15'h0000, drive_enable_out});
    endtask

    task automatic t_power_up();
        check("status", fhe_pkg::STATUS_RESET, status_word_out);
        check("count", fhe_pkg::COUNT_RESET, fault_count_out);
        for (int i = 1; i <= 64; i += 21) rd_entry(i[7:0], 16'h0000);
    endtask

    task automatic t_enable();
        ctl(16'h0000, 16'h0001);
        ctl(16'h000F, 16'h0037);
        ctl(16'h000D, 16'h0021);
        ctl(16'h000F, 16'h0037);
        ctl(16'h0007, 16'h0031);
        ctl(16'h000F, 16'h0037);
    endtask

    task automatic t_faults();
        raise_fault(32'h0020_0008, 16'h0001);
        rd_entry(8'h01, 16'h0004);
        rd_entry(8'h02, 16'h0016);
        rd_entry(8'h03, 16'h0000);
        ctl(16'h000E, 16'h0038);
        ctl(16'h000F, 16'h0038);
        raise_fault(32'h1020_0008, 16'h0002);
        rd_entry(8'h03, 16'h001D);
        rd_entry(8'h09, 16'h0004);
        rd_entry(8'h0A, 16'h0016);
        rd_entry(8'h0B, 16'h0000);
    endtask

    task automatic t_acknowledge();
        ctl(16'h008F, 16'h0038);
        ctl(16'h000F, 16'h0038);
        @(negedge clk_in);
        fault_cause_in = 32'h0000_0000;
        ctl(16'h008F, 16'h0070);
        rd_entry(8'h03, 16'h001D);
        ctl(16'h000E, 16'h0031);
        ctl(16'h000F, 16'h0037);
    endtask

    task automatic t_many_causes();
        raise_fault(32'h0000_03FF, 16'h0003);
        for (int i = 1; i <= 8; i++) rd_entry(i[7:0], i[15:0]);
        rd_entry(8'h09, 16'h0004);
        rd_entry(8'h13, 16'h0000);
        rd_entry(8'h11, 16'h0004);
    endtask

    task automatic t_channel();
        req(fhe_pkg::TASK_READ, fhe_pkg::PNU_COUNT, 8'h00, 16'h0000, 1'b0, 16'h0003);
        req(fhe_pkg::TASK_WRITE, fhe_pkg::PNU_COUNT, 8'h00, 16'h0005, 1'b1, 16'h0000);
        check("count", 16'h0003, fault_count_out);
        req(fhe_pkg::TASK_WRITE, fhe_pkg::PNU_COUNT, 8'h00, 16'h0000, 1'b0, 16'h0000);
        check("count", fhe_pkg::COUNT_RESET, fault_count_out);
        req(fhe_pkg::TASK_READ, fhe_pkg::PNU_CAUSE, 8'h00, 16'h0000, 1'b1, 16'h0000);
        req(fhe_pkg::TASK_READ, fhe_pkg::PNU_CAUSE, 8'h41, 16'h0000, 1'b1, 16'h0000);
        rd_entry(fhe_pkg::INDEX_LAST, 16'h0000);
        req(fhe_pkg::TASK_WRITE, fhe_pkg::PNU_CAUSE, 8'h01, 16'h0000, 1'b1, 16'h0000);
        req(4'h3, fhe_pkg::PNU_CAUSE, 8'h01, 16'h0000, 1'b1, 16'h0000);
        rd_entry(8'h01, 16'h0001);
    endtask

    task automatic t_power_cycle();
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_power_up();
    endtask

    initial begin
        rst_n_in = 1'b0;
        fault_cause_in = 32'h0000_0000;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_power_up();
        t_enable();
        t_faults();
        t_acknowledge();
        t_many_causes();
        t_channel();
        @(negedge clk_in);
        fault_cause_in = 32'h0000_0000;
        t_power_cycle();
        finish_test();
    end
endmodule

`default_nettype wire

// ==== sim/fhe_master_model.sv ====
// Behavioural fieldbus master: parameter channel requests and the control word.
`default_nettype none

module fhe_master_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic        error_in,
    input  wire logic [15:0] rdata_in,
    output var  logic        valid_out,
    output var  logic [3:0]  task_out,
    output var  logic [10:0] pnu_out,
    output var  logic [7:0]  index_out,
    output var  logic [15:0] wdata_out,
    output var  logic [15:0] control_word_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        valid_out = 1'b0;
        task_out = 4'h0;
        pnu_out = 11'h000;
        index_out = 8'h00;
        wdata_out = 16'h0000;
        control_word_out = 16'h0000;
    end

    // One strobe per request; the answer is taken one edge later. Gap cycles model a slow master.
    task automatic request(input logic [3:0] tid, input logic [10:0] pnu, input logic [7:0] idx,
                           input logic [15:0] wd, input int gap,
                           output logic got, output logic err, output logic [15:0] rd);
        @(negedge clk_in);
        repeat (gap) @(negedge clk_in);
        valid_out = 1'b1;
        task_out = tid;
        pnu_out = pnu;
        index_out = idx;
        wdata_out = wd;
        @(negedge clk_in);
        got = ack_in;
        err = error_in;
        rd = rdata_in;
        valid_out = 1'b0;
        // Released fields are scrambled so that a stale value is never mistaken for a held one.
        task_out = ~tid;
        pnu_out = ~pnu;
        index_out = ~idx;
        wdata_out = ~wd;
    endtask

    task automatic set_control(input logic [15:0] cw);
        @(negedge clk_in);
        control_word_out = cw;
    endtask
endmodule

`default_nettype wire
